// [common/mact_pkg.sv]
// Purpose: Shared types and constants for the memory access cycle timing engine
// Assumes: One memory/CPU bus clock drives every user of this package
// Notes:   Each pattern packs eight 4-bit figures; the top nibble is the first-word latency
package mact_pkg;

  localparam int MACT_FIG_W     = 4;
  localparam int MACT_GAPS      = 7;
  localparam int MACT_FIRST_LSB = 28;
  localparam int MACT_SUM_W     = 8;

  typedef enum logic [1:0] {
    MACT_MEM_SDRAM = 2'h0,
    MACT_MEM_EDO   = 2'h1,
    MACT_MEM_FPM   = 2'h2,
    MACT_MEM_FLASH = 2'h3
  } mact_mem_t;

  // Memory configuration of the range being accessed
  typedef struct packed {
    mact_mem_t  mem;          // Device technology
    logic [1:0] grade;        // Speed grade; only one grade per technology is timed
    logic       interleave;   // Bank-interleaved range
    logic       page_mode;    // Open page kept in this range
    logic       page_hit;     // Access falls in the open page
    logic       module_range; // Plug-in module range, else base memory
  } mact_cfg_t;

  // CPU memory command
  typedef struct packed {
    logic write;       // Write command, else read
    logic line;        // Eight-word cache line, else one or two words
    logic two_words;   // Two-word single access
    logic offset_zero; // Access starts at word offset 0
    logic sequential;  // Address follows the previous access
  } mact_req_t;

  typedef logic [31:0] mact_pat_t;

  localparam mact_pat_t MACT_PAT_SD_BASE_RD   = 32'h9111_1111;
  localparam mact_pat_t MACT_PAT_SD_BASE_WR   = 32'h7111_1111;
  localparam mact_pat_t MACT_PAT_SD_MOD_RD    = 32'hB131_3131;
  localparam mact_pat_t MACT_PAT_SD_MOD_WR    = 32'h9444_4444;
  localparam mact_pat_t MACT_PAT_EDO_RD       = 32'h9222_2222;
  localparam mact_pat_t MACT_PAT_EDO_IL_RD    = 32'h9111_1111;
  localparam mact_pat_t MACT_PAT_EDO_PM_RD    = 32'hD111_1111;
  localparam mact_pat_t MACT_PAT_EDO_SEQ_RD   = 32'h3121_1111;
  localparam mact_pat_t MACT_PAT_EDO_HIT_RD   = 32'h7111_1111;
  localparam mact_pat_t MACT_PAT_EDO_WR       = 32'h7222_2222;
  localparam mact_pat_t MACT_PAT_EDO_IL_WR    = 32'h7222_0000;
  localparam mact_pat_t MACT_PAT_EDO_PM_WR    = 32'hB222_0000;
  localparam mact_pat_t MACT_PAT_EDO_HIT_WR   = 32'h5222_0000;
  localparam mact_pat_t MACT_PAT_EDO_MIL_RD   = 32'hB131_3131;
  localparam mact_pat_t MACT_PAT_EDO_MOD_RD   = 32'hB444_4444;
  localparam mact_pat_t MACT_PAT_EDO_MIL_WR   = 32'h9444_0000;
  localparam mact_pat_t MACT_PAT_EDO_MOD_WR   = 32'h9444_4444;
  localparam mact_pat_t MACT_PAT_FPM_IL_RD    = 32'hB141_4141;
  localparam mact_pat_t MACT_PAT_FPM_RD       = 32'hB555_5555;
  localparam mact_pat_t MACT_PAT_FPM_IL_WR    = 32'hA555_0000;
  localparam mact_pat_t MACT_PAT_FPM_WR       = 32'hA555_5555;
  localparam mact_pat_t MACT_PAT_FL_IL_RD     = 32'hD161_6161;
  localparam mact_pat_t MACT_PAT_FL_RD        = 32'hD777_7777;
  localparam mact_pat_t MACT_PAT_FL_IL_WR     = 32'hB666_0000;
  localparam mact_pat_t MACT_PAT_FL_WR        = 32'hB666_6666;

  localparam logic [3:0] MACT_XFER_LINE = 4'h8;
  localparam logic [3:0] MACT_XFER_DW   = 4'h4;
  localparam logic [3:0] MACT_XFER_TWO  = 4'h2;
  localparam logic [3:0] MACT_XFER_ONE  = 4'h1;
  localparam logic [3:0] MACT_CNT_FIRE  = 4'h1;
  localparam logic [7:0] MACT_SINCE_ONE = 8'h01;

endpackage

// [rtl/mact_gap_counter.sv]
// Purpose: Down counter that fires once a loaded number of clocks has passed
// Assumes: Load value is at least one
// Notes:   Fires in the cycle the count reaches one; a load in that cycle chains the next gap
`timescale 1ns/10ps
module mact_gap_counter #(
  parameter int W = 4
) (
  input  wire logic         clk,      // Bus clock
  input  wire logic         rst,      // Asynchronous reset, active high
  input  wire logic         ce,       // Clock enable
  input  wire logic         load,     // Start a new count
  input  wire logic [W-1:0] load_val, // Clocks until fire
  output logic              fire      // Count has elapsed
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_ff <= load_val;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - W'(1);
      end
    end
  end

  assign fire = ce && (cnt_ff == W'(1));

endmodule // mact_gap_counter

// [rtl/mact_engine.sv]
// Purpose: Cycle timing of CPU line fills and writes against local memory
// Assumes: Command and configuration come from logic on the same clock
// Notes:   Counts are bus clocks; word strobes mark each transfer on the CPU side
// Summary of operation
// - A cache line fill is eight word transfers timed in bus clocks.
// - Latency counts from the command edge; later figures are gaps between words.
// - Next operation waits until the summed write figures have elapsed.
// - Interleaved writes move double-words, so a line write is four transfers.
// - Line fill after short offset-zero read uses page-hit timing, not sequential.
// - Base SDRAM read: first word at 9 clocks, then one clock apart.
// - Base SDRAM write: first word at 7 clocks, then one clock apart.
// - Module SDRAM read: 11 clocks, then gaps 1,3,1,3,1,3,1.
// - Module SDRAM write: 9 clocks, then four clocks per word.
// - Interleaved page-mode EDO sequential hit read: 3, then 1,2,1,1,1,1,1.
`timescale 1ns/10ps
module mact_engine (
  input  wire logic              clk,            // Bus clock, 25 MHz
  input  wire logic              rst,            // Asynchronous reset, active high
  input  wire logic              ce,             // Clock enable; low freezes all state
  input  wire logic              cpu_req,        // CPU command valid
  input  wire mact_pkg::mact_req_t cpu_cmd,      // CPU command
  input  wire mact_pkg::mact_cfg_t mem_cfg,      // Configuration of the target range
  output logic                   cpu_ready,      // Command may be taken this cycle
  output logic                   cpu_word_strobe,// One word moves this cycle
  output logic [2:0]             cpu_word_idx,   // Index of the word moving
  output logic                   cpu_word_write, // Current operation is a write
  output logic                   cpu_busy        // Operation in progress
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } mact_state_t;

  mact_state_t         state_ff;
  mact_pkg::mact_pat_t pat_ff;
  logic [3:0]          xfers_ff;
  logic [2:0]          word_cnt_ff;
  logic                write_ff;
  logic                prev_short_ff;
  logic [7:0]          since_ff;
  logic [7:0]          total_ff;
  logic [7:0]          last_fire_ff;

  logic                take;
  logic                fire;
  logic                last;
  logic                seq_eff;
  logic                cnt_load;
  logic [3:0]          cnt_val;
  mact_pkg::mact_pat_t nxt_pat;
  logic [3:0]          nxt_xfers;

  function automatic logic [3:0] first_of(mact_pkg::mact_pat_t p);
    return p[mact_pkg::MACT_FIRST_LSB +: mact_pkg::MACT_FIG_W];
  endfunction

  function automatic logic [3:0] gap_of(mact_pkg::mact_pat_t p, logic [2:0] k);
    return p[(mact_pkg::MACT_GAPS - 1 - int'(k)) * mact_pkg::MACT_FIG_W +: mact_pkg::MACT_FIG_W];
  endfunction

  function automatic logic [7:0] total_of(mact_pkg::mact_pat_t p, logic [3:0] n);
    logic [7:0] s;
    s = 8'(first_of(p));
    for (int i = 0; i < mact_pkg::MACT_GAPS; i++) begin
      if (4'(i + 1) < n) begin
        s = s + 8'(gap_of(p, 3'(i)));
      end
    end
    return s;
  endfunction

  // Nearest listed timing for every configuration
  function automatic mact_pkg::mact_pat_t select_pat(mact_pkg::mact_cfg_t c, logic wr,
                                                     logic seq);
    mact_pkg::mact_pat_t p;
    p = mact_pkg::MACT_PAT_SD_BASE_RD;
    unique case (c.mem)
      mact_pkg::MACT_MEM_SDRAM: begin
        if (c.module_range) begin
          p = wr ? mact_pkg::MACT_PAT_SD_MOD_WR : mact_pkg::MACT_PAT_SD_MOD_RD;
        end else begin
          p = wr ? mact_pkg::MACT_PAT_SD_BASE_WR : mact_pkg::MACT_PAT_SD_BASE_RD;
        end
      end
      mact_pkg::MACT_MEM_EDO: begin
        if (c.module_range) begin
          if (wr) begin
            p = c.interleave ? mact_pkg::MACT_PAT_EDO_MIL_WR : mact_pkg::MACT_PAT_EDO_MOD_WR;
          end else begin
            p = c.interleave ? mact_pkg::MACT_PAT_EDO_MIL_RD : mact_pkg::MACT_PAT_EDO_MOD_RD;
          end
        end else if (!c.interleave) begin
          p = wr ? mact_pkg::MACT_PAT_EDO_WR : mact_pkg::MACT_PAT_EDO_RD;
        end else if (!c.page_mode) begin
          p = wr ? mact_pkg::MACT_PAT_EDO_IL_WR : mact_pkg::MACT_PAT_EDO_IL_RD;
        end else if (!c.page_hit) begin
          p = wr ? mact_pkg::MACT_PAT_EDO_PM_WR : mact_pkg::MACT_PAT_EDO_PM_RD;
        end else if (wr) begin
          p = mact_pkg::MACT_PAT_EDO_HIT_WR;
        end else begin
          p = seq ? mact_pkg::MACT_PAT_EDO_SEQ_RD : mact_pkg::MACT_PAT_EDO_HIT_RD;
        end
      end
      mact_pkg::MACT_MEM_FPM: begin
        if (wr) begin
          p = c.interleave ? mact_pkg::MACT_PAT_FPM_IL_WR : mact_pkg::MACT_PAT_FPM_WR;
        end else begin
          p = c.interleave ? mact_pkg::MACT_PAT_FPM_IL_RD : mact_pkg::MACT_PAT_FPM_RD;
        end
      end
      mact_pkg::MACT_MEM_FLASH: begin
        if (wr) begin
          p = c.interleave ? mact_pkg::MACT_PAT_FL_IL_WR : mact_pkg::MACT_PAT_FL_WR;
        end else begin
          p = c.interleave ? mact_pkg::MACT_PAT_FL_IL_RD : mact_pkg::MACT_PAT_FL_RD;
        end
      end
    endcase
    return p;
  endfunction

  // A fill following a short offset-zero read loses the sequential timing
  assign seq_eff = cpu_cmd.sequential && !(cpu_cmd.line && prev_short_ff);
  assign nxt_pat = select_pat(mem_cfg, cpu_cmd.write, seq_eff);

  always_comb begin
    if (cpu_cmd.write && mem_cfg.interleave) begin
      nxt_xfers = cpu_cmd.line ? mact_pkg::MACT_XFER_DW : mact_pkg::MACT_XFER_ONE;
    end else if (cpu_cmd.line) begin
      nxt_xfers = mact_pkg::MACT_XFER_LINE;
    end else begin
      nxt_xfers = cpu_cmd.two_words ? mact_pkg::MACT_XFER_TWO : mact_pkg::MACT_XFER_ONE;
    end
  end

  // Ready also in the last transfer so a new command starts exactly at the sum
  assign last      = fire && ({1'b0, word_cnt_ff} == (xfers_ff - mact_pkg::MACT_XFER_ONE));
  assign cpu_ready = ce && ((state_ff == ST_IDLE) || last);
  assign take      = cpu_req && cpu_ready;

  // Write data arrives back to back, so each figure is the memory-side rate
  assign cnt_load = take || (fire && !last);
  assign cnt_val  = take ? first_of(nxt_pat) : gap_of(pat_ff, word_cnt_ff);

  mact_gap_counter #(
    .W (mact_pkg::MACT_FIG_W)
  ) u_gap (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .load     (cnt_load),
    .load_val (cnt_val),
    .fire     (fire)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else if (ce) begin
      if (take) begin
        state_ff <= ST_RUN;
      end else if (last) begin
        state_ff <= ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pat_ff   <= mact_pkg::MACT_PAT_SD_BASE_RD;
      xfers_ff <= mact_pkg::MACT_XFER_ONE;
      write_ff <= 1'b0;
      total_ff <= '0;
    end else if (ce && take) begin
      pat_ff   <= nxt_pat;
      xfers_ff <= nxt_xfers;
      write_ff <= cpu_cmd.write;
      total_ff <= total_of(nxt_pat, nxt_xfers);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_cnt_ff <= '0;
    end else if (ce) begin
      if (take) begin
        word_cnt_ff <= '0;
      end else if (fire && !last) begin
        word_cnt_ff <= word_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_short_ff <= 1'b0;
    end else if (ce && take) begin
      prev_short_ff <= !cpu_cmd.line && !cpu_cmd.write && cpu_cmd.offset_zero;
    end
  end

  // Clocks since the command edge; that edge is cycle zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_ff     <= '0;
      last_fire_ff <= '0;
    end else if (ce) begin
      if (take) begin
        since_ff <= mact_pkg::MACT_SINCE_ONE;
      end else if (state_ff == ST_RUN) begin
        since_ff <= since_ff + mact_pkg::MACT_SINCE_ONE;
      end
      if (fire) begin
        last_fire_ff <= since_ff;
      end
    end
  end

  assign cpu_word_strobe = fire;
  assign cpu_word_idx    = word_cnt_ff;
  assign cpu_word_write  = write_ff;
  assign cpu_busy        = (state_ff == ST_RUN);

  property p_line_eight;
    @(posedge clk) disable iff (rst)
      (take && cpu_cmd.line && !(cpu_cmd.write && mem_cfg.interleave))
      |=> (xfers_ff == mact_pkg::MACT_XFER_LINE);
  endproperty
  a_line_eight: assert property (p_line_eight) else $error("line fill not eight words");

  property p_first_latency;
    @(posedge clk) disable iff (rst)
      (fire && (word_cnt_ff == '0)) |-> (since_ff == 8'(first_of(pat_ff)));
  endproperty
  a_first_latency: assert property (p_first_latency) else $error("first word mistimed");

  property p_word_gap;
    @(posedge clk) disable iff (rst)
      (fire && (word_cnt_ff != '0))
      |-> ((since_ff - last_fire_ff) == 8'(gap_of(pat_ff, word_cnt_ff - 3'h1)));
  endproperty
  a_word_gap: assert property (p_word_gap) else $error("word gap mistimed");

  property p_sum_elapsed;
    @(posedge clk) disable iff (rst)
      (cpu_busy && cpu_ready) |-> (since_ff == total_ff);
  endproperty
  a_sum_elapsed: assert property (p_sum_elapsed) else $error("ready before sum elapsed");

  property p_dw_write;
    @(posedge clk) disable iff (rst)
      (take && cpu_cmd.write && cpu_cmd.line && mem_cfg.interleave)
      |=> (xfers_ff == mact_pkg::MACT_XFER_DW) ##0 !cpu_ready [*3];
  endproperty
  a_dw_write: assert property (p_dw_write) else $error("interleaved write not four");

  property p_after_short;
    @(posedge clk) disable iff (rst)
      (take && cpu_cmd.line && !cpu_cmd.write && prev_short_ff)
      |=> (pat_ff != mact_pkg::MACT_PAT_EDO_SEQ_RD);
  endproperty
  a_after_short: assert property (p_after_short) else $error("sequential timing after short read");

  property p_sd_base_rd;
    @(posedge clk) disable iff (rst)
      (take && (mem_cfg.mem == mact_pkg::MACT_MEM_SDRAM) && !mem_cfg.module_range
       && !cpu_cmd.write && cpu_cmd.line) |=> (pat_ff == mact_pkg::MACT_PAT_SD_BASE_RD);
  endproperty
  a_sd_base_rd: assert property (p_sd_base_rd) else $error("base SDRAM read pattern");

  property p_sd_base_wr;
    @(posedge clk) disable iff (rst)
      (take && (mem_cfg.mem == mact_pkg::MACT_MEM_SDRAM) && !mem_cfg.module_range
       && cpu_cmd.write) |=> (pat_ff == mact_pkg::MACT_PAT_SD_BASE_WR);
  endproperty
  a_sd_base_wr: assert property (p_sd_base_wr) else $error("base SDRAM write pattern");

  property p_sd_mod_rd;
    @(posedge clk) disable iff (rst)
      (take && (mem_cfg.mem == mact_pkg::MACT_MEM_SDRAM) && mem_cfg.module_range
       && !cpu_cmd.write) |=> (pat_ff == mact_pkg::MACT_PAT_SD_MOD_RD);
  endproperty
  a_sd_mod_rd: assert property (p_sd_mod_rd) else $error("module SDRAM read pattern");

  property p_sd_mod_wr;
    @(posedge clk) disable iff (rst)
      (take && (mem_cfg.mem == mact_pkg::MACT_MEM_SDRAM) && mem_cfg.module_range
       && cpu_cmd.write) |=> (pat_ff == mact_pkg::MACT_PAT_SD_MOD_WR);
  endproperty
  a_sd_mod_wr: assert property (p_sd_mod_wr) else $error("module SDRAM write pattern");

  property p_edo_seq;
    @(posedge clk) disable iff (rst)
      (take && (mem_cfg.mem == mact_pkg::MACT_MEM_EDO) && !mem_cfg.module_range
       && mem_cfg.interleave && mem_cfg.page_mode && mem_cfg.page_hit && !cpu_cmd.write
       && cpu_cmd.sequential && !(cpu_cmd.line && prev_short_ff))
      |=> (pat_ff == mact_pkg::MACT_PAT_EDO_SEQ_RD);
  endproperty
  a_edo_seq: assert property (p_edo_seq) else $error("EDO sequential hit pattern");

  property p_pattern_set;
    @(posedge clk) disable iff (rst)
      cpu_busy |-> (first_of(pat_ff) != '0) && (xfers_ff != '0);
  endproperty
  a_pattern_set: assert property (p_pattern_set) else $error("no timing selected");

endmodule // mact_engine

// [testbench/mact_cpu_model.sv]
// Purpose: CPU bus master that issues memory commands to the timing engine
// Assumes: Engine takes a command on the edge where request and ready are both high
// Notes:   Released command lines show inverted values so stale data is never trusted
`timescale 1ns/10ps
module mact_cpu_model (
  input  wire logic           clk,       // Bus clock
  input  wire logic           cpu_ready, // Engine can take a command
  output logic                cpu_req,   // Command valid
  output mact_pkg::mact_req_t cpu_cmd,   // Command fields
  output mact_pkg::mact_cfg_t mem_cfg    // Target range configuration
);
  int cyc = 0;
  int take_cyc = 0;

  initial begin
    cpu_req = 1'b0;
    cpu_cmd = '0;
    mem_cfg = '0;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // Holds the command until ready is seen, then lets go at the take edge
  task automatic send(input mact_pkg::mact_req_t c, input mact_pkg::mact_cfg_t g);
    int n;
    n = 0;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_cmd <= c;
    mem_cfg <= g;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 200);
    take_cyc = cyc;
    @(posedge clk);
    // Write data would follow on back-to-back clocks; this master never stalls
    cpu_req <= 1'b0;
    cpu_cmd <= mact_pkg::mact_req_t'(~c);
    mem_cfg <= mact_pkg::mact_cfg_t'(~g);
  endtask
endmodule // mact_cpu_model

// [testbench/tb_mact_engine.sv]
// Purpose: Self-checking bench for the memory access cycle timing engine
// Assumes: One bus clock; the engine counts cycles only while enabled
// Notes:   Strobes and levels are sampled at the falling edge where they are settled
`timescale 1ns/10ps
module tb_mact_engine;
  logic                clk;
  logic                rst;
  logic                ce;
  logic                cpu_req;
  mact_pkg::mact_req_t cpu_cmd;
  mact_pkg::mact_cfg_t mem_cfg;
  logic                cpu_ready;
  logic                cpu_word_strobe;
  logic [2:0]          cpu_word_idx;
  logic                cpu_word_write;
  logic                cpu_busy;
  int                  n_fail;
  int                  n_compared;

  mact_engine u_dut (
    .clk(clk), .rst(rst), .ce(ce), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd),
    .mem_cfg(mem_cfg), .cpu_ready(cpu_ready), .cpu_word_strobe(cpu_word_strobe),
    .cpu_word_idx(cpu_word_idx), .cpu_word_write(cpu_word_write), .cpu_busy(cpu_busy)
  );

  mact_cpu_model u_cpu (
    .clk(clk), .cpu_ready(cpu_ready), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd),
    .mem_cfg(mem_cfg)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic mact_pkg::mact_req_t rq(logic w, logic l, logic t, logic z, logic s);
    return '{w, l, t, z, s};
  endfunction

  function automatic mact_pkg::mact_cfg_t cf(mact_pkg::mact_mem_t m, logic i, logic p,
                                             logic h, logic md);
    return '{m, 2'h0, i, p, h, md};
  endfunction

  // One operation; pat nibbles are first latency then gaps; st_at freezes three cycles
  task automatic op(input mact_pkg::mact_req_t c, input mact_pkg::mact_cfg_t g,
                    input logic [31:0] pat, input int nx, input int st_at);
    int offs[8];
    int eff;
    int st;
    int k;
    int hit;
    offs[0] = pat[31:28];
    for (k = 1; k < 8; k++) begin
      offs[k] = offs[k-1] + pat[31-4*k -: 4];
    end
    u_cpu.send(c, g);
    eff = 1;
    st = 0;
    while (eff <= offs[nx-1]) begin
      @(negedge clk);
      hit = -1;
      for (k = 0; k < nx; k++) begin
        if (ce && offs[k] == eff) hit = k;
      end
      chk("strobe", hit >= 0, cpu_word_strobe);
      chk("ready", ce && eff == offs[nx-1], cpu_ready);
      chk("busy", 1, cpu_busy);
      if (hit >= 0) begin
        chk("idx", hit, cpu_word_idx);
        chk("write", c.write, cpu_word_write);
      end
      if (ce) eff++;
      @(posedge clk);
      if (eff == st_at && st < 3) begin
        ce <= 1'b0;
        st++;
      end else begin
        ce <= 1'b1;
      end
    end
    @(negedge clk);
    chk("busy_end", 0, cpu_busy);
    chk("ready_end", 1, cpu_ready);
  endtask

  task automatic t_sd_base_rd();
    op(rq(0, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 0), 32'h9111_1111, 8, 0);
  endtask

  task automatic t_sd_base_wr();
    op(rq(1, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 0), 32'h7111_1111, 8, 0);
  endtask

  task automatic t_sd_mod_rd_stall();
    op(rq(0, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 1), 32'hB131_3131, 8, 5);
  endtask

  task automatic t_sd_mod_wr();
    op(rq(1, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 1), 32'h9444_4444, 8, 0);
  endtask

  task automatic t_edo_seq_hit();
    op(rq(0, 1, 0, 0, 1), cf(mact_pkg::MACT_MEM_EDO, 1, 1, 1, 0), 32'h3121_1111, 8, 0);
  endtask

  task automatic t_short_then_line();
    op(rq(0, 0, 1, 1, 0), cf(mact_pkg::MACT_MEM_EDO, 1, 1, 1, 0), 32'h7111_1111, 2, 0);
    op(rq(0, 1, 0, 0, 1), cf(mact_pkg::MACT_MEM_EDO, 1, 1, 1, 0), 32'h7111_1111, 8, 0);
  endtask

  task automatic t_interleaved_writes();
    op(rq(1, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_EDO, 1, 0, 0, 0), 32'h7222_0000, 4, 0);
    op(rq(1, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_FLASH, 1, 0, 0, 1), 32'hB666_0000, 4, 0);
  endtask

  // Remaining memory type FPM, a non-interleaved EDO read and a lone interleaved write word
  task automatic t_other_modes();
    op(rq(0, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_FPM, 1, 0, 0, 1), 32'hB141_4141, 8, 0);
    op(rq(0, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_EDO, 0, 0, 0, 0), 32'h9222_2222, 8, 0);
    op(rq(1, 0, 0, 0, 0), cf(mact_pkg::MACT_MEM_EDO, 1, 1, 1, 0), 32'h5222_0000, 1, 0);
  endtask

  // Reset in mid-operation drops the transfer and leaves the engine idle
  task automatic t_mid_reset();
    u_cpu.send(rq(0, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 0));
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk("mid_rst_busy", 0, cpu_busy);
    chk("mid_rst_strobe", 0, cpu_word_strobe);
    chk("mid_rst_ready", 1, cpu_ready);
    @(posedge clk);
    rst <= 1'b0;
    op(rq(0, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 0), 32'h9111_1111, 8, 0);
  endtask

  // Second write waits with its request up; it must be taken 37 clocks after the first
  task automatic t_back_to_back();
    int t0;
    u_cpu.send(rq(1, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 1));
    t0 = u_cpu.take_cyc;
    u_cpu.send(rq(1, 1, 0, 0, 0), cf(mact_pkg::MACT_MEM_SDRAM, 0, 0, 0, 1));
    chk("take_gap", 37, u_cpu.take_cyc - t0);
    repeat (40) @(posedge clk);
  endtask

  initial begin
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("rst_busy", 0, cpu_busy);
    chk("rst_strobe", 0, cpu_word_strobe);
    chk("rst_ready", 1, cpu_ready);
    @(posedge clk);
    rst <= 1'b0;
    t_sd_base_rd();
    t_sd_base_wr();
    t_sd_mod_rd_stall();
    t_sd_mod_wr();
    t_edo_seq_hit();
    t_short_then_line();
    t_interleaved_writes();
    t_other_modes();
    t_mid_reset();
    t_back_to_back();
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule // tb_mact_engine
